// ### design/pmtr_core.sv
// program memory with instruction fetch and look-up table reads
//
// How it works
// - 16-bit program words, 4K or 8K deep
// - after reset, execution starts at word zero
// - table address is high pointer then low
// - low table byte goes to named register
// - high table byte goes to holding register
// - sector 0 basic forms, others need extended
// - full forms use both pointer registers
// - last-page forms use last page, low offset
// - every accepted table instruction takes two cycles; a refused one only raises the refusal pulse
// - holding register readable and writable by software
// - programming data on one pin, external clock
// - emulation variant disables shared pin functions while debugging
// - debug pins still serve as programming pins
`timescale 1ns/1ns
`default_nettype none
`include "pmtr_map.svh"
module pmtr_core #(
  parameter int ADDR_W = 12,
  parameter bit EMU_VARIANT = 1'b0,
  parameter int SECTOR_W = 2
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // instruction fetch from the core
  input wire logic [ADDR_W-1:0] fetch_addr_i,
  output logic [15:0] fetch_word_o,
  output logic reset_vector_valid_o,
  output logic [ADDR_W-1:0] reset_vector_o,
  // table pointer registers, held by the core
  input wire logic [7:0] table_ptr_low_i,
  input wire logic [7:0] table_ptr_high_i,
  // table read request
  input wire logic table_req_i,
  input wire pmtr_pkg::pmtr_op_t table_op_i,
  input wire logic [SECTOR_W-1:0] table_dest_sector_i,
  input wire logic [7:0] table_dest_addr_i,
  output logic table_busy_o,
  output logic table_done_o,
  output logic table_illegal_o,
  output logic table_wr_en_o,
  output logic [SECTOR_W-1:0] table_wr_sector_o,
  output logic [7:0] table_wr_addr_o,
  output logic [7:0] table_wr_data_o,
  // software access to the holding register
  input wire logic table_high_byte_wr_i,
  input wire logic [7:0] table_high_byte_wdata_i,
  output logic [7:0] table_high_byte_o,
  // programming port, loads one word at a time
  input wire logic prog_mode_i,
  input wire logic prog_we_i,
  input wire logic [ADDR_W-1:0] prog_addr_i,
  input wire logic [15:0] prog_wdata_i,
  // shared serial pins
  input wire logic prog_serial_data_i,
  output logic prog_serial_data_o,
  output logic prog_serial_data_oe_o,
  input wire logic prog_serial_clock_i,
  input wire logic [15:0] prog_serial_rdata_i,
  input wire logic prog_serial_rdata_oe_i,
  output logic prog_serial_data_sync_o,
  output logic prog_serial_clock_sync_o,
  input wire logic debug_active_i,
  input wire logic alt_func_data_i,
  input wire logic alt_func_clock_i,
  output logic alt_func_data_o,
  output logic alt_func_clock_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  localparam int DEPTH = 1 << ADDR_W;
  logic [`PMTR_WORD_W-1:0] mem [DEPTH];

  // sequencer state and captured request, declared up here because
  // the reset-vector logic below already looks at the state
  pmtr_pkg::pmtr_state_t state_reg;
  pmtr_pkg::pmtr_state_t state_next;
  logic [ADDR_W-1:0] taddr_reg;
  logic [15:0] table_word;
  logic accept;

  // pointer concatenation or last-page offset
  function automatic logic [ADDR_W-1:0] table_addr(
    input pmtr_pkg::pmtr_op_t op,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [15:0] full;
    full = {hi, lo};
    if (op == pmtr_pkg::PMTR_OP_FULL_BASIC ||
        op == pmtr_pkg::PMTR_OP_FULL_EXT) begin
      table_addr = full[ADDR_W-1:0];
    end else begin
      table_addr = {{(ADDR_W-8){1'b1}}, lo};
    end
  endfunction

  // basic forms only reach sector 0
  function automatic logic op_legal(
    input pmtr_pkg::pmtr_op_t op,
    input logic [SECTOR_W-1:0] sec
  );
    op_legal = (op == pmtr_pkg::PMTR_OP_PAGE_EXT) ||
               (op == pmtr_pkg::PMTR_OP_FULL_EXT) ||
               (sec == '0);
  endfunction

  // ----------------------------------------------------------------
  // programming write port and fetch
  // ----------------------------------------------------------------
  // no reset on the array: it is nonvolatile content
  // and must map onto a plain memory macro
  always_ff @(posedge clk_sys_i) begin
    if (prog_mode_i && prog_we_i) begin
      mem[prog_addr_i] <= prog_wdata_i;
    end
  end

  // registered fetch, one cycle latency
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_word_o <= 16'h0000;
    end else begin
      fetch_word_o <= mem[fetch_addr_i];
    end
  end

  // reset entry point offered once after reset release
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reset_vector_valid_o <= 1'b0;
    end else begin
      reset_vector_valid_o <= (state_reg == pmtr_pkg::PMTR_ST_BOOT);
    end
  end

  // entry address is fixed at word zero
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reset_vector_o <= '0;
    end else begin
      reset_vector_o <= ADDR_W'(`PMTR_RESET_VECTOR);
    end
  end

  // ----------------------------------------------------------------
  // table read sequencer
  // ----------------------------------------------------------------
  // requests arriving while busy are dropped silently; the core never
  // issues one, since the instruction itself holds for both cycles
  assign accept = table_req_i && (state_reg == pmtr_pkg::PMTR_ST_IDLE) &&
                  op_legal(table_op_i, table_dest_sector_i);

  // two-cycle sequence: address, then write-back
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pmtr_pkg::PMTR_ST_BOOT: state_next = pmtr_pkg::PMTR_ST_IDLE;
      pmtr_pkg::PMTR_ST_IDLE: begin
        if (accept) begin
          state_next = pmtr_pkg::PMTR_ST_READ;
        end
      end
      pmtr_pkg::PMTR_ST_READ: state_next = pmtr_pkg::PMTR_ST_DONE;
      pmtr_pkg::PMTR_ST_DONE: state_next = pmtr_pkg::PMTR_ST_IDLE;
      default: state_next = pmtr_pkg::PMTR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= pmtr_pkg::PMTR_ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // pointers are sampled, never modified here
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      taddr_reg <= '0;
      table_wr_sector_o <= '0;
      table_wr_addr_o <= 8'h00;
    end else if (accept) begin
      taddr_reg <= table_addr(table_op_i, table_ptr_low_i,
                              table_ptr_high_i);
      table_wr_sector_o <= table_dest_sector_i;
      table_wr_addr_o <= table_dest_addr_i;
    end
  end

  // one read of the addressed word feeds both halves of the answer
  assign table_word = mem[taddr_reg];

  // ----------------------------------------------------------------
  // write-back
  // ----------------------------------------------------------------
  // strobe and done pulse during the second cycle of the two
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      table_wr_en_o <= 1'b0;
      table_done_o <= 1'b0;
    end else begin
      table_wr_en_o <= (state_reg == pmtr_pkg::PMTR_ST_READ);
      table_done_o <= (state_reg == pmtr_pkg::PMTR_ST_READ);
    end
  end

  // refusal pulse: a basic form aimed past sector 0
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      table_illegal_o <= 1'b0;
    end else begin
      table_illegal_o <= table_req_i &&
                         (state_reg == pmtr_pkg::PMTR_ST_IDLE) &&
                         !op_legal(table_op_i, table_dest_sector_i);
    end
  end

  // low byte stands until the next read overwrites it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      table_wr_data_o <= 8'h00;
    end else if (state_reg == pmtr_pkg::PMTR_ST_READ) begin
      table_wr_data_o <= table_word[7:0];
    end
  end

  assign table_busy_o = (state_reg != pmtr_pkg::PMTR_ST_IDLE);

  // ----------------------------------------------------------------
  // holding register
  // ----------------------------------------------------------------
  // holding register: table load wins over a software write,
  // so a read landing with a save never loses its data
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      table_high_byte_o <= `PMTR_TABLE_HIGH_BYTE_RESET;
    end else if (state_reg == pmtr_pkg::PMTR_ST_READ) begin
      table_high_byte_o <= table_word[15:8];
    end else if (table_high_byte_wr_i) begin
      table_high_byte_o <= table_high_byte_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // serial pins
  // ----------------------------------------------------------------
  logic sda_meta_reg;
  logic sck_meta_reg;

  // two-stage synchroniser for the programmer data pin
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sda_meta_reg <= 1'b0;
      prog_serial_data_sync_o <= 1'b0;
    end else begin
      sda_meta_reg <= prog_serial_data_i;
      prog_serial_data_sync_o <= sda_meta_reg;
    end
  end

  // the clock pin is external and unrelated, so it gets two flops too
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sck_meta_reg <= 1'b0;
      prog_serial_clock_sync_o <= 1'b0;
    end else begin
      sck_meta_reg <= prog_serial_clock_i;
      prog_serial_clock_sync_o <= sck_meta_reg;
    end
  end

  // data pin is two-way; the clock is only ever driven from outside
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prog_serial_data_o <= 1'b0;
      prog_serial_data_oe_o <= 1'b0;
    end else begin
      prog_serial_data_o <= prog_serial_rdata_i[0];
      prog_serial_data_oe_o <= prog_mode_i &&
                               prog_serial_rdata_oe_i;
    end
  end

  // shared functions go dead on the emulation part while debugging;
  // the production part keeps them live, so debug pins stay usable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      alt_func_data_o <= 1'b0;
      alt_func_clock_o <= 1'b0;
    end else if (EMU_VARIANT && debug_active_i) begin
      alt_func_data_o <= 1'b0;
      alt_func_clock_o <= 1'b0;
    end else begin
      alt_func_data_o <= alt_func_data_i;
      alt_func_clock_o <= alt_func_clock_i;
    end
  end

endmodule
`default_nettype wire

// ### inc/pmtr_map.svh
// constants for the program memory table-read block
`ifndef PMTR_MAP_SVH
`define PMTR_MAP_SVH
`define PMTR_WORD_W 16
`define PMTR_DEPTH_SMALL 4096
`define PMTR_DEPTH_LARGE 8192
`define PMTR_RESET_VECTOR 13'h0000
`define PMTR_TBH_RESET 8'h00
`define PMTR_TBL_RESET 8'h00
`define PMTR_TABLE_HIGH_BYTE_RESET 8'h00
`define PMTR_TABLE_CYCLES 2
`endif

// ### inc/pmtr_pkg.sv
// types for the program memory table-read block
package pmtr_pkg;
  typedef enum logic [1:0] {
    PMTR_OP_PAGE_BASIC,
    PMTR_OP_FULL_BASIC,
    PMTR_OP_PAGE_EXT,
    PMTR_OP_FULL_EXT
  } pmtr_op_t;
  typedef enum {
    PMTR_ST_BOOT,
    PMTR_ST_IDLE,
    PMTR_ST_READ,
    PMTR_ST_DONE
  } pmtr_state_t;
endpackage

// ### tb/pmtr_core_props.sv
// checker for the table-read block
`timescale 1ns/1ns
`default_nettype none
module pmtr_core_props #(parameter int ADDR_W = 12,
  parameter bit EMU_VARIANT = 1'b0, parameter int SECTOR_W = 2) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // table request
  input wire logic table_req_i,
  input wire pmtr_pkg::pmtr_op_t table_op_i,
  input wire logic [SECTOR_W-1:0] table_dest_sector_i,
  input wire logic [7:0] table_dest_addr_i,
  // table answer
  input wire logic table_busy_o,
  input wire logic table_done_o,
  input wire logic table_illegal_o,
  input wire logic table_wr_en_o,
  input wire logic [SECTOR_W-1:0] table_wr_sector_o,
  input wire logic [7:0] table_wr_addr_o,
  // holding register, vector, shared pins
  input wire logic table_high_byte_wr_i,
  input wire logic [7:0] table_high_byte_wdata_i,
  input wire logic [7:0] table_high_byte_o,
  input wire logic reset_vector_valid_o,
  input wire logic [ADDR_W-1:0] reset_vector_o,
  input wire logic debug_active_i,
  input wire logic alt_func_data_i,
  input wire logic alt_func_data_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // basic forms reach sector zero only
  wire logic ok = table_op_i >= pmtr_pkg::PMTR_OP_PAGE_EXT ||
    table_dest_sector_i == '0;
  wire logic go = table_req_i && !table_busy_o && ok;
  property p_take; go |=> table_busy_o ##1 table_done_o && table_wr_en_o;
  endproperty
  a_take: assert property (p_take) else $error("late table answer");
  property p_dest; go |-> ##2 table_wr_addr_o == $past(table_dest_addr_i, 2)
    && table_wr_sector_o == $past(table_dest_sector_i, 2); endproperty
  a_dest: assert property (p_dest) else $error("wrong target");
  property p_refuse; table_req_i && !table_busy_o && !ok |=> table_illegal_o
    && !table_wr_en_o ##1 !table_wr_en_o; endproperty
  a_refuse: assert property (p_refuse) else $error("not refused");
  property p_end; table_wr_en_o |-> table_busy_o ##1 !table_busy_o; endproperty
  a_end: assert property (p_end) else $error("busy too long");
  property p_hold; $changed(table_high_byte_o) |-> table_wr_en_o ||
    $past(table_high_byte_wr_i); endproperty
  a_hold: assert property (p_hold) else $error("high byte moved");
  property p_swwr; table_high_byte_wr_i && !table_busy_o |=>
    table_high_byte_o == $past(table_high_byte_wdata_i); endproperty
  a_swwr: assert property (p_swwr) else $error("sw write lost");
  property p_vec; reset_vector_valid_o |-> reset_vector_o == '0 ##1
    !reset_vector_valid_o; endproperty
  a_vec: assert property (p_vec) else $error("bad reset vector");
  property p_alt; !$past(rst_i) |-> alt_func_data_o == ($past(alt_func_data_i)
    && !(EMU_VARIANT && $past(debug_active_i))); endproperty
  a_alt: assert property (p_alt) else $error("shared pin active");
  c_take: cover property (go);
  c_refuse: cover property (table_illegal_o);
  c_swwr: cover property (table_high_byte_wr_i && !table_busy_o);
endmodule
bind pmtr_core pmtr_core_props #(.ADDR_W(ADDR_W), .EMU_VARIANT(EMU_VARIANT),
  .SECTOR_W(SECTOR_W)) i_pmtr_core_props (.clk_sys_i, .rst_i, .table_req_i,
  .table_op_i, .table_dest_sector_i, .table_dest_addr_i, .table_busy_o,
  .table_done_o, .table_illegal_o, .table_wr_en_o, .table_wr_sector_o,
  .table_wr_addr_o, .table_high_byte_wr_i, .table_high_byte_wdata_i,
  .table_high_byte_o, .reset_vector_valid_o, .reset_vector_o,
  .debug_active_i, .alt_func_data_i, .alt_func_data_o);
`default_nettype wire

// ### tb/pmtr_cpu_model.sv
// core model: data memory that takes the table low bytes
`timescale 1ns/1ns
`default_nettype none
module pmtr_cpu_model (
  // clock and destination write
  input wire logic clk_sys_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_sector_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i
);
  logic [7:0] dmem [0:1023];
  // sector and offset pick the register
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      dmem[{wr_sector_i, wr_addr_i}] <= wr_data_i;
    end
  end
endmodule
`default_nettype wire

// ### tb/pmtr_tb.sv
// self-checking bench for the table-read block
`timescale 1ns/1ns
`default_nettype none
module program_memory_table_read_tb_top;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, table_req_i = 1'b0, pck = 1'b0;
  logic table_high_byte_wr_i = 1'b0, prog_mode_i = 1'b0, prog_we_i = 1'b0;
  logic prog_serial_rdata_oe_i = 1'b0, debug_active_i = 1'b0, pdat = 1'b0;
  logic alt_func_data_i = 1'b0, alt_func_clock_i = 1'b0, v;
  logic [11:0] fetch_addr_i = 12'h000, prog_addr_i = 12'h000, reset_vector_o;
  logic [7:0] table_ptr_low_i = 8'h00, table_ptr_high_i = 8'h00;
  logic [7:0] table_dest_addr_i = 8'h00, table_high_byte_wdata_i = 8'h00;
  logic [7:0] table_wr_addr_o, table_wr_data_o, table_high_byte_o;
  logic [1:0] table_dest_sector_i = 2'h0, table_wr_sector_o;
  logic [15:0] prog_wdata_i = 16'h0000, prog_serial_rdata_i = 16'h0000;
  logic [15:0] fetch_word_o, w, seed = 16'h17b2, sh [0:4095];
  logic reset_vector_valid_o, table_busy_o, table_done_o, table_illegal_o;
  logic table_wr_en_o, prog_serial_data_o, prog_serial_data_oe_o;
  logic prog_serial_data_sync_o, prog_serial_clock_sync_o;
  logic alt_func_data_o, alt_func_clock_o;
  pmtr_pkg::pmtr_op_t table_op_i = pmtr_pkg::PMTR_OP_PAGE_BASIC;
  int n_errors = 0, num_checks = 0;
  // the programmer drives the data pin only while the device lets go
  wire logic pin = prog_serial_data_oe_o ? prog_serial_data_o : pdat;
  pmtr_core #(.ADDR_W(12), .EMU_VARIANT(1'b1), .SECTOR_W(2)) i_pmtr_core (
    .clk_sys_i, .rst_i, .fetch_addr_i, .fetch_word_o, .reset_vector_valid_o,
    .reset_vector_o, .table_ptr_low_i, .table_ptr_high_i, .table_req_i,
    .table_op_i, .table_dest_sector_i, .table_dest_addr_i, .table_busy_o,
    .table_done_o, .table_illegal_o, .table_wr_en_o, .table_wr_sector_o,
    .table_wr_addr_o, .table_wr_data_o, .table_high_byte_wr_i,
    .table_high_byte_wdata_i, .table_high_byte_o, .prog_mode_i, .prog_we_i,
    .prog_addr_i, .prog_wdata_i, .prog_serial_data_i(pin), .prog_serial_data_o,
    .prog_serial_data_oe_o, .prog_serial_clock_i(pck), .prog_serial_rdata_i,
    .prog_serial_rdata_oe_i, .prog_serial_data_sync_o,
    .prog_serial_clock_sync_o, .debug_active_i, .alt_func_data_i,
    .alt_func_clock_i, .alt_func_data_o, .alt_func_clock_o);
  pmtr_cpu_model i_pmtr_cpu_model (.clk_sys_i, .wr_en_i(table_wr_en_o),
    .wr_sector_i(table_wr_sector_o), .wr_addr_i(table_wr_addr_o),
    .wr_data_i(table_wr_data_o));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // 16-bit xorshift, fixed start so runs repeat
  function automatic logic [15:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one table read; page forms get a junk high pointer on purpose
  task automatic tread(input logic [1:0] op, input logic [1:0] sec);
    logic [15:0] x, y;
    logic [7:0] hb, old;
    logic ill;
    int n;
    int dn;
    x = rnd();
    y = rnd();
    hb = table_high_byte_o;
    old = i_pmtr_cpu_model.dmem[{sec, y[7:0]}];
    w = sh[op[0] ? {x[11:8], x[7:0]} : {4'hf, x[7:0]}];
    @(posedge clk_sys_i);
    table_req_i <= 1'b1;
    table_op_i <= pmtr_pkg::pmtr_op_t'(op);
    {table_ptr_high_i, table_ptr_low_i} <= x;
    {table_dest_sector_i, table_dest_addr_i} <= {sec, y[7:0]};
    @(posedge clk_sys_i);
    table_req_i <= 1'b0;
    // the refusal pulse stands only in the cycle after the take edge
    #1 ill = table_illegal_o;
    n = 0;
    dn = 0;
    // count edges until busy drops; done must pulse exactly once
    while (table_busy_o === 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      #1 n++;
      if (table_done_o === 1'b1) begin
        dn++;
      end
    end
    @(posedge clk_sys_i);
    #1;
    if (op[1] || sec == 2'h0) begin
      chk("cycles", 16'(n), 16'h0002);
      chk("done", 16'(dn), 16'h0001);
      chk("low", 16'(i_pmtr_cpu_model.dmem[{sec, y[7:0]}]), w[7:0]);
      chk("high", 16'(table_high_byte_o), w[15:8]);
    end else begin
      chk("refused", 16'(ill), 16'h0001);
      chk("kept", 16'(i_pmtr_cpu_model.dmem[{sec, y[7:0]}]), old);
      chk("high_kept", 16'(table_high_byte_o), hb);
    end
  endtask
  // long enough for the memory fill plus all reads
  initial begin
    #(40 * 20000);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    v = 1'b0;
    repeat (3) begin
      @(posedge clk_sys_i);
      #1 v |= reset_vector_valid_o;
    end
    chk("vector", {v, 3'h0, reset_vector_o}, 16'h8000);
    $display("reset test done");
    for (int i = 0; i < 4096; i++) begin
      @(posedge clk_sys_i);
      {prog_mode_i, prog_we_i} <= 2'h3;
      prog_addr_i <= i[11:0];
      sh[i] = rnd();
      prog_wdata_i <= sh[i];
    end
    @(posedge clk_sys_i);
    {prog_mode_i, prog_we_i} <= 2'h0;
    for (int j = 0; j < 8; j++) begin
      w = rnd();
      w[11:0] = j == 0 ? 12'h000 : j == 1 ? 12'hfff : w[11:0];
      @(posedge clk_sys_i);
      fetch_addr_i <= w[11:0];
      @(posedge clk_sys_i);
      #1 chk("fetch", fetch_word_o, sh[w[11:0]]);
    end
    $display("fetch test done");
    for (int j = 0; j < 60; j++) begin
      w = rnd();
      if (j == 30) begin
        @(posedge clk_sys_i);
        table_high_byte_wr_i <= 1'b1;
        table_high_byte_wdata_i <= w[15:8];
        @(posedge clk_sys_i);
        table_high_byte_wr_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        #1 chk("sw_high", 16'(table_high_byte_o), w[15:8]);
      end
      tread(j < 4 ? 2'(j) : w[1:0], w[2] ? w[4:3] : 2'h0);
    end
    $display("table test done");
    for (int j = 0; j < 8; j++) begin
      w = rnd();
      @(posedge clk_sys_i);
      {pck, pdat, debug_active_i, alt_func_data_i} <= w[3:0];
      alt_func_clock_i <= w[7];
      {prog_mode_i, prog_serial_rdata_oe_i} <= w[5:4];
      prog_serial_rdata_i <= {15'h0000, w[6]};
      repeat (3) @(posedge clk_sys_i);
      #1 chk("alt", 16'(alt_func_data_o), 16'(w[0] & !w[1]));
      chk("clk_sync", 16'(prog_serial_clock_sync_o), w[3]);
      chk("alt_clk", 16'(alt_func_clock_o), 16'(w[7] & !w[1]));
      v = &w[5:4] ? w[6] : w[2];
      chk("dat_sync", 16'(prog_serial_data_sync_o), 16'(v));
    end
    $display("pin test done");
    end_of_test();
  end
endmodule
`default_nettype wire
